// ### hdl/svq_map.svh
`ifndef SVQ_MAP_SVH
`define SVQ_MAP_SVH
// register offsets, byte addresses on the register port
`define SVQ_REG_CTRL 8'h00
`define SVQ_REG_QSIZE 8'h04
`define SVQ_REG_DESC_LO 8'h08
`define SVQ_REG_DESC_HI 8'h0c
`define SVQ_REG_AVAIL_LO 8'h10
`define SVQ_REG_AVAIL_HI 8'h14
`define SVQ_REG_USED_LO 8'h18
`define SVQ_REG_USED_HI 8'h1c
`define SVQ_REG_NOTIFY 8'h20
`define SVQ_REG_STATUS 8'h24
`define SVQ_REG_INDEX 8'h28
`define SVQ_REG_LIMIT 8'h2c
`define SVQ_REG_PFN 8'h30
// control field positions
`define SVQ_CTRL_ENABLE 0
`define SVQ_CTRL_IN_ORDER 1
`define SVQ_CTRL_LEGACY 2
`define SVQ_CTRL_BIG_END 3
// descriptor flag values
`define SVQ_F_NEXT 16'h0001
`define SVQ_F_WRITE 16'h0002
`define SVQ_F_INDIRECT 16'h0004
// queue layout in bytes
`define SVQ_AVAIL_IDX_OFS 64'h2
`define SVQ_AVAIL_RING_OFS 64'h4
`define SVQ_AVAIL_HDR_TAIL 64'h6
`define SVQ_USED_IDX_OFS 64'h2
`define SVQ_USED_RING_OFS 64'h4
`define SVQ_USED_LEN_OFS 64'h4
`define SVQ_QALIGN_MASK 64'h0000_0000_0000_0fff
`define SVQ_QSIZE_RESET 16'h0100
`define SVQ_LIMIT_RESET 16'h0040
// error causes
`define SVQ_ERR_NONE 3'h0
`define SVQ_ERR_CHAIN 3'h1
`define SVQ_ERR_INDEX 3'h2
`define SVQ_ERR_NEST 3'h3
`define SVQ_ERR_QSIZE 3'h4
`endif

// ### hdl/svq_pkg.sv
package svq_pkg;
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [31:0] wdata;
  } svq_reg_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [63:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
  } svq_mem_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
    logic last;
  } svq_stream_t;

  typedef enum logic [12:0] {
    S_IDLE = 13'h0001,
    S_AIDX = 13'h0002,
    S_AENT = 13'h0004,
    S_DESC = 13'h0008,
    S_DECIDE = 13'h0010,
    S_NEXT = 13'h0020,
    S_BRD = 13'h0040,
    S_BOUT = 13'h0080,
    S_BIN = 13'h0100,
    S_BWR = 13'h0200,
    S_UID = 13'h0400,
    S_ULEN = 13'h0800,
    S_UIDX = 13'h1000
  } svq_state_t;
endpackage

// ### hdl/svq_engine.sv
// Implementation choices: the address map and strobed register access.
`include "svq_map.svh"
`timescale 1ns/100ps
`default_nettype none
module svq_engine (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // register port
  input wire svq_pkg::svq_reg_req_t i_reg,
  output logic [31:0] o_reg_rdata,
  // guest memory master
  output svq_pkg::svq_mem_req_t o_mem,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  // readable buffer data towards the device function
  output svq_pkg::svq_stream_t o_out,
  input wire logic i_out_ready,
  // data from the device function into writable buffers
  input wire svq_pkg::svq_stream_t i_in,
  output logic o_in_ready,
  // events
  input wire logic i_avail_notify,
  output logic o_used_notify,
  output logic o_error
);
  logic [3:0] ctrl;
  logic [15:0] qsize;
  logic [63:0] desc_base;
  logic [63:0] avail_base;
  logic [63:0] used_base;
  logic [15:0] chain_limit;
  logic pending;
  logic [2:0] err_code;
  svq_pkg::svq_state_t state;
  logic [15:0] last_avail;
  logic [15:0] used_idx;
  logic [15:0] head;
  logic [15:0] cur_idx;
  logic [63:0] tbl_base;
  logic [27:0] tbl_size;
  logic in_ind;
  logic [1:0] wcnt;
  logic [31:0] dw [4];
  logic [16:0] count;
  logic [31:0] used_len;
  logic [63:0] buf_addr;
  logic [31:0] buf_rem;
  logic buf_wr;
  logic msg_done;
  logic hsel;

  function automatic logic [31:0] swap32(input logic [31:0] w);
    swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
  function automatic logic [15:0] swap16(input logic [15:0] h);
    swap16 = {h[7:0], h[15:8]};
  endfunction
  function automatic svq_pkg::svq_mem_req_t mk_req(input logic wr, input logic [63:0] a,
                                                    input logic [31:0] d, input logic [3:0] s);
    mk_req = '{valid: 1'b1, write: wr, addr: {a[63:2], 2'b00}, wdata: d, strb: s};
  endfunction

  // register decode
  wire wr_ctrl = i_reg.write && i_reg.addr == `SVQ_REG_CTRL;
  wire wr_qsize = i_reg.write && i_reg.addr == `SVQ_REG_QSIZE;
  wire wr_pfn = i_reg.write && i_reg.addr == `SVQ_REG_PFN;
  wire wr_notify = i_reg.write && i_reg.addr == `SVQ_REG_NOTIFY;
  wire err_clr = i_reg.write && i_reg.addr == `SVQ_REG_STATUS && i_reg.wdata[0];
  wire [15:0] q_new = i_reg.wdata[15:0];
  // a zero or non power of two size is refused and flagged
  wire q_ok = q_new != 16'h0 && (q_new & (q_new - 16'h1)) == 16'h0;
  wire qsize_bad = wr_qsize && !q_ok;
  wire idx_clear = wr_ctrl && i_reg.wdata[`SVQ_CTRL_ENABLE] && !ctrl[`SVQ_CTRL_ENABLE];
  wire big_end = ctrl[`SVQ_CTRL_LEGACY] && ctrl[`SVQ_CTRL_BIG_END];
  wire run = ctrl[`SVQ_CTRL_ENABLE] && !o_error;

  // legacy page layout from one page frame number
  wire [63:0] lg_desc = {20'h0, i_reg.wdata, 12'h000};
  wire [63:0] lg_avail = lg_desc + {44'h0, qsize, 4'h0};
  wire [63:0] lg_av_end = lg_avail + `SVQ_AVAIL_HDR_TAIL + {47'h0, qsize, 1'b0};
  wire [63:0] lg_used = (lg_av_end + `SVQ_QALIGN_MASK) & ~`SVQ_QALIGN_MASK;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl <= 4'h0;
      qsize <= `SVQ_QSIZE_RESET;
      desc_base <= 64'h0;
      avail_base <= 64'h0;
      used_base <= 64'h0;
      chain_limit <= `SVQ_LIMIT_RESET;
    end else if (i_reg.write) begin
      if (wr_ctrl) ctrl <= i_reg.wdata[3:0];
      if (wr_qsize && q_ok) qsize <= q_new;
      if (i_reg.addr == `SVQ_REG_DESC_LO) desc_base[31:0] <= i_reg.wdata;
      if (i_reg.addr == `SVQ_REG_DESC_HI) desc_base[63:32] <= i_reg.wdata;
      if (i_reg.addr == `SVQ_REG_AVAIL_LO) avail_base[31:0] <= i_reg.wdata;
      if (i_reg.addr == `SVQ_REG_AVAIL_HI) avail_base[63:32] <= i_reg.wdata;
      if (i_reg.addr == `SVQ_REG_USED_LO) used_base[31:0] <= i_reg.wdata;
      if (i_reg.addr == `SVQ_REG_USED_HI) used_base[63:32] <= i_reg.wdata;
      if (i_reg.addr == `SVQ_REG_LIMIT) chain_limit <= i_reg.wdata[15:0];
      if (wr_pfn) begin
        desc_base <= lg_desc;
        avail_base <= lg_avail;
        used_base <= lg_used;
      end
    end
  end

  wire [31:0] status_word = {16'h0, 1'b0, state != svq_pkg::S_IDLE, pending, 9'h0,
                             err_code, o_error};
  wire [31:0] rd_mux =
    (i_reg.addr == `SVQ_REG_CTRL) ? {28'h0, ctrl} :
    (i_reg.addr == `SVQ_REG_QSIZE) ? {16'h0, qsize} :
    (i_reg.addr == `SVQ_REG_DESC_LO) ? desc_base[31:0] :
    (i_reg.addr == `SVQ_REG_DESC_HI) ? desc_base[63:32] :
    (i_reg.addr == `SVQ_REG_AVAIL_LO) ? avail_base[31:0] :
    (i_reg.addr == `SVQ_REG_AVAIL_HI) ? avail_base[63:32] :
    (i_reg.addr == `SVQ_REG_USED_LO) ? used_base[31:0] :
    (i_reg.addr == `SVQ_REG_USED_HI) ? used_base[63:32] :
    (i_reg.addr == `SVQ_REG_STATUS) ? status_word :
    (i_reg.addr == `SVQ_REG_INDEX) ? {used_idx, last_avail} :
    (i_reg.addr == `SVQ_REG_LIMIT) ? {16'h0, chain_limit} :
    32'h0;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) o_reg_rdata <= 32'h0;
    else o_reg_rdata <= i_reg.read ? rd_mux : 32'h0;
  end

  // queue addressing
  wire [15:0] qmask = qsize - 16'h1;
  wire [15:0] aslot = last_avail & qmask;
  wire [15:0] uslot = used_idx & qmask;
  wire [63:0] a_aidx = avail_base + `SVQ_AVAIL_IDX_OFS;
  wire [63:0] a_aent = avail_base + `SVQ_AVAIL_RING_OFS + {47'h0, aslot, 1'b0};
  wire [63:0] a_desc = tbl_base + {44'h0, cur_idx, 4'h0} + {60'h0, wcnt, 2'b00};
  wire [63:0] a_uid = used_base + `SVQ_USED_RING_OFS + {45'h0, uslot, 3'h0};
  wire [63:0] a_ulen = a_uid + `SVQ_USED_LEN_OFS;
  wire [63:0] a_uidx = used_base + `SVQ_USED_IDX_OFS;

  // memory data in the guest's byte order
  wire [15:0] rd_half_raw = hsel ? i_mem_rdata[31:16] : i_mem_rdata[15:0];
  wire [15:0] rd_half = big_end ? swap16(rd_half_raw) : rd_half_raw;
  wire [63:0] d_addr = big_end ? {swap32(dw[0]), swap32(dw[1])} : {dw[1], dw[0]};
  wire [31:0] d_len = big_end ? swap32(dw[2]) : dw[2];
  wire [15:0] d_flags = big_end ? swap16(dw[3][15:0]) : dw[3][15:0];
  wire [15:0] d_next = big_end ? swap16(dw[3][31:16]) : dw[3][31:16];
  wire f_next = (d_flags & `SVQ_F_NEXT) != 16'h0;
  wire f_write = (d_flags & `SVQ_F_WRITE) != 16'h0;
  wire f_ind = (d_flags & `SVQ_F_INDIRECT) != 16'h0;
  wire [16:0] count_new = count + 17'h1;
  wire too_long = count_new > {1'b0, chain_limit} || count_new > {1'b0, qsize};
  wire adv_err = {12'h0, d_next} >= tbl_size;
  wire ring_empty = rd_half == last_avail;

  // bytes moved by the current buffer word
  wire [2:0] nbytes = (buf_rem >= 32'h4) ? 3'h4 : buf_rem[2:0];
  wire [3:0] wstrb = (nbytes == 3'h4) ? 4'hf : (nbytes == 3'h3) ? 4'h7 :
                     (nbytes == 3'h2) ? 4'h3 : 4'h1;
  wire [31:0] id_word = big_end ? swap32({16'h0, head}) : {16'h0, head};
  wire [31:0] len_word = big_end ? swap32(used_len) : used_len;
  wire [15:0] uidx_new = used_idx + 16'h1;
  wire [15:0] uidx_half = big_end ? swap16(uidx_new) : uidx_new;
  wire [31:0] uidx_data = a_uidx[1] ? {uidx_half, 16'h0} : {16'h0, uidx_half};
  wire [3:0] uidx_strb = a_uidx[1] ? 4'hc : 4'h3;
  wire mem_done = o_mem.valid && i_mem_ack;
  wire pend_clr = state == svq_pkg::S_AIDX && mem_done && ring_empty;

  // a doorbell in the same cycle as the empty-ring clear keeps the flag set
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) pending <= 1'b0;
    else if (wr_notify || i_avail_notify) pending <= 1'b1;
    else if (pend_clr) pending <= 1'b0;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= svq_pkg::S_IDLE;
      o_mem <= '0;
      o_out <= '0;
      o_in_ready <= 1'b0;
      o_used_notify <= 1'b0;
      o_error <= 1'b0;
      err_code <= `SVQ_ERR_NONE;
      last_avail <= 16'h0;
      used_idx <= 16'h0;
      head <= 16'h0;
      cur_idx <= 16'h0;
      tbl_base <= 64'h0;
      tbl_size <= 28'h0;
      in_ind <= 1'b0;
      wcnt <= 2'h0;
      dw <= '{default: 32'h0};
      count <= 17'h0;
      used_len <= 32'h0;
      buf_addr <= 64'h0;
      buf_rem <= 32'h0;
      buf_wr <= 1'b0;
      msg_done <= 1'b0;
      hsel <= 1'b0;
    end else begin
      o_used_notify <= 1'b0;
      if (idx_clear) begin
        last_avail <= 16'h0;
        used_idx <= 16'h0;
      end
      if (err_clr) begin
        o_error <= 1'b0;
        err_code <= `SVQ_ERR_NONE;
      end
      if (qsize_bad) begin
        o_error <= 1'b1;
        err_code <= `SVQ_ERR_QSIZE;
      end
      case (state)
        svq_pkg::S_IDLE: begin
          if (run && pending) state <= svq_pkg::S_AIDX;
        end
        svq_pkg::S_AIDX: begin
          if (!o_mem.valid) begin
            o_mem <= mk_req(1'b0, a_aidx, 32'h0, 4'hf);
            hsel <= a_aidx[1];
          end else if (i_mem_ack) begin
            o_mem.valid <= 1'b0;
            state <= ring_empty ? svq_pkg::S_IDLE : svq_pkg::S_AENT;
          end
        end
        svq_pkg::S_AENT: begin
          if (!o_mem.valid) begin
            o_mem <= mk_req(1'b0, a_aent, 32'h0, 4'hf);
            hsel <= a_aent[1];
          end else if (i_mem_ack) begin
            o_mem.valid <= 1'b0;
            head <= rd_half;
            cur_idx <= rd_half;
            tbl_base <= desc_base;
            tbl_size <= {12'h0, qsize};
            in_ind <= 1'b0;
            count <= 17'h0;
            used_len <= 32'h0;
            msg_done <= 1'b0;
            wcnt <= 2'h0;
            if (rd_half >= qsize) begin
              o_error <= 1'b1;
              err_code <= `SVQ_ERR_INDEX;
              state <= svq_pkg::S_IDLE;
            end else begin
              state <= svq_pkg::S_DESC;
            end
          end
        end
        svq_pkg::S_DESC: begin
          if (!o_mem.valid) begin
            o_mem <= mk_req(1'b0, a_desc, 32'h0, 4'hf);
          end else if (i_mem_ack) begin
            o_mem.valid <= 1'b0;
            dw[wcnt] <= i_mem_rdata;
            wcnt <= wcnt + 2'h1;
            if (wcnt == 2'h3) state <= svq_pkg::S_DECIDE;
          end
        end
        svq_pkg::S_DECIDE: begin
          count <= count_new;
          buf_addr <= d_addr;
          buf_rem <= d_len;
          buf_wr <= f_write;
          if (too_long) begin
            o_error <= 1'b1;
            err_code <= `SVQ_ERR_CHAIN;
            state <= svq_pkg::S_IDLE;
          end else if (f_ind) begin
            // the write flag of a table pointer carries no meaning
            if (in_ind) begin
              o_error <= 1'b1;
              err_code <= `SVQ_ERR_NEST;
              state <= svq_pkg::S_IDLE;
            end else begin
              in_ind <= 1'b1;
              tbl_base <= d_addr;
              tbl_size <= d_len[31:4];
              cur_idx <= 16'h0;
              state <= svq_pkg::S_DESC;
            end
          end else if (d_len == 32'h0 || (f_write && msg_done)) begin
            state <= svq_pkg::S_NEXT;
          end else begin
            // readable and writable pieces may be mixed in any order
            state <= f_write ? svq_pkg::S_BIN : svq_pkg::S_BRD;
          end
        end
        svq_pkg::S_NEXT: begin
          if (!f_next) begin
            state <= svq_pkg::S_UID;
          end else if (adv_err) begin
            o_error <= 1'b1;
            err_code <= `SVQ_ERR_INDEX;
            state <= svq_pkg::S_IDLE;
          end else begin
            cur_idx <= d_next;
            state <= svq_pkg::S_DESC;
          end
        end
        svq_pkg::S_BRD: begin
          if (!o_mem.valid) begin
            o_mem <= mk_req(1'b0, buf_addr, 32'h0, 4'hf);
          end else if (i_mem_ack) begin
            o_mem.valid <= 1'b0;
            o_out <= '{valid: 1'b1, data: i_mem_rdata, last: buf_rem <= 32'h4};
            state <= svq_pkg::S_BOUT;
          end
        end
        svq_pkg::S_BOUT: begin
          if (i_out_ready) begin
            o_out.valid <= 1'b0;
            buf_rem <= buf_rem - {29'h0, nbytes};
            buf_addr <= buf_addr + 64'h4;
            state <= (buf_rem <= 32'h4) ? svq_pkg::S_NEXT : svq_pkg::S_BRD;
          end
        end
        svq_pkg::S_BIN: begin
          if (!o_in_ready) begin
            o_in_ready <= 1'b1;
          end else if (i_in.valid) begin
            o_in_ready <= 1'b0;
            msg_done <= i_in.last;
            o_mem <= mk_req(1'b1, buf_addr, i_in.data, wstrb);
            state <= svq_pkg::S_BWR;
          end
        end
        svq_pkg::S_BWR: begin
          if (i_mem_ack) begin
            o_mem.valid <= 1'b0;
            used_len <= used_len + {29'h0, nbytes};
            buf_rem <= buf_rem - {29'h0, nbytes};
            buf_addr <= buf_addr + 64'h4;
            state <= (buf_rem <= 32'h4 || msg_done) ? svq_pkg::S_NEXT : svq_pkg::S_BIN;
          end
        end
        svq_pkg::S_UID: begin
          if (!o_mem.valid) begin
            o_mem <= mk_req(1'b1, a_uid, id_word, 4'hf);
          end else if (i_mem_ack) begin
            o_mem.valid <= 1'b0;
            state <= svq_pkg::S_ULEN;
          end
        end
        svq_pkg::S_ULEN: begin
          if (!o_mem.valid) begin
            o_mem <= mk_req(1'b1, a_ulen, len_word, 4'hf);
          end else if (i_mem_ack) begin
            o_mem.valid <= 1'b0;
            state <= svq_pkg::S_UIDX;
          end
        end
        svq_pkg::S_UIDX: begin
          if (!o_mem.valid) begin
            o_mem <= mk_req(1'b1, a_uidx, uidx_data, uidx_strb);
          end else if (i_mem_ack) begin
            // one chain at a time, so completion follows posting order
            o_mem.valid <= 1'b0;
            used_idx <= uidx_new;
            last_avail <= last_avail + 16'h1;
            o_used_notify <= 1'b1;
            state <= svq_pkg::S_IDLE;
          end
        end
        default: state <= svq_pkg::S_IDLE;
      endcase
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  a_notify_after_idx: assert property (
    o_used_notify |-> $past(state == svq_pkg::S_UIDX && mem_done))
    else $error("used notification without used index write");
  a_no_write_readable: assert property (
    (o_mem.valid && o_mem.write && state == svq_pkg::S_BWR) |->
      buf_wr && o_mem.addr[63:2] == buf_addr[63:2])
    else $error("write into a device-readable buffer");
  a_len_report: assert property (
    (state == svq_pkg::S_ULEN && o_mem.valid && !big_end) |-> o_mem.wdata == used_len)
    else $error("used length differs from bytes written");
  a_chain_bound: assert property (
    (state == svq_pkg::S_DECIDE && too_long) |=> state == svq_pkg::S_IDLE && o_error)
    else $error("over-long chain not stopped");
  a_qsize_pow2: assert property (
    qsize != 16'h0 && (qsize & (qsize - 16'h1)) == 16'h0)
    else $error("queue size not a power of two");
  a_in_order: assert property (
    o_used_notify |-> used_idx == last_avail)
    else $error("completion out of posting order");
  a_used_writer: assert property (
    (o_mem.valid && o_mem.write) |-> (state == svq_pkg::S_BWR || state == svq_pkg::S_UID ||
      state == svq_pkg::S_ULEN || state == svq_pkg::S_UIDX))
    else $error("device write outside used ring or writable buffer");
  a_read_only_rd: assert property (
    (state == svq_pkg::S_BRD) |-> !buf_wr)
    else $error("device read of a writable buffer");
  a_next_follow: assert property (
    (state == svq_pkg::S_NEXT && f_next && !adv_err) |=>
      state == svq_pkg::S_DESC && cur_idx == $past(d_next))
    else $error("chain not continued at next index");
endmodule
`default_nettype wire

// ### tb/svq_guest_mem.sv
`timescale 1ns/100ps
`default_nettype none
module svq_guest_mem (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // engine memory port
  input wire svq_pkg::svq_mem_req_t i_mem,
  output logic o_ack,
  output logic [31:0] o_rdata,
  // answer after three extra cycles when high
  input wire logic i_slow
);
  logic [31:0] mem [logic [63:0]];
  logic [1:0] wait_cnt;
  logic [31:0] cur;
  // bench lays out aligned little-endian queue parts here
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ack <= 1'b0;
      wait_cnt <= 2'h0;
      o_rdata <= 32'h0;
    end else if (i_mem.valid && !o_ack && (!i_slow || wait_cnt == 2'h3)) begin
      cur = mem.exists(i_mem.addr) ? mem[i_mem.addr] : ~i_mem.addr[31:0];
      for (int b = 0; b < 4; b++) begin
        if (i_mem.write && i_mem.strb[b]) cur[8*b +: 8] = i_mem.wdata[8*b +: 8];
      end
      if (i_mem.write) mem[i_mem.addr] = cur;
      o_rdata <= cur;
      o_ack <= 1'b1;
      wait_cnt <= 2'h0;
    end else begin
      // idle read data keeps changing so a late sample never looks valid
      o_rdata <= ~o_rdata;
      o_ack <= 1'b0;
      if (i_mem.valid && !o_ack) wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ### tb/split_virtqueue_descriptor_engine_test.sv
`include "svq_map.svh"
`timescale 1ns/100ps
`default_nettype none
module split_virtqueue_descriptor_engine_test;
  localparam logic [63:0] DB = 64'h1000;
  localparam logic [63:0] AB = 64'h1040;
  localparam logic [63:0] UB = 64'h2000;
  localparam logic [63:0] RB = 64'h3000;
  localparam logic [63:0] WB = 64'h3100;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  svq_pkg::svq_reg_req_t rq = '0;
  svq_pkg::svq_mem_req_t mq;
  svq_pkg::svq_stream_t out_s;
  svq_pkg::svq_stream_t in_s = '0;
  logic [31:0] rdata;
  logic [31:0] mrd;
  logic mack;
  logic out_rdy = 1'b0;
  logic in_rdy;
  logic kick = 1'b0;
  logic used_ev;
  logic err;
  logic slow = 1'b0;
  int err_count = 0;
  int samples_checked = 0;
  logic [32:0] outq[$];
  always #25 clk = ~clk;
  svq_engine i_svq_engine (.i_clock(clk), .i_arst_n(arst_n), .i_reg(rq), .o_reg_rdata(rdata),
    .o_mem(mq), .i_mem_ack(mack), .i_mem_rdata(mrd), .o_out(out_s), .i_out_ready(out_rdy),
    .i_in(in_s), .o_in_ready(in_rdy), .i_avail_notify(kick), .o_used_notify(used_ev),
    .o_error(err));
  svq_guest_mem i_svq_guest_mem (.i_clock(clk), .i_arst_n(arst_n), .i_mem(mq), .o_ack(mack),
    .o_rdata(mrd), .i_slow(slow));
  // consumer stalls every other cycle
  always @(posedge clk) begin
    out_rdy <= ~out_rdy;
    if (out_s.valid && out_rdy) outq.push_back({out_s.last, out_s.data});
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] pk(input logic [63:0] a);
    return i_svq_guest_mem.mem[a];
  endfunction
  function automatic void po(input logic [63:0] a, input logic [31:0] d);
    i_svq_guest_mem.mem[a] = d;
  endfunction
  function automatic void ent(input logic [63:0] t, input int i, input logic [63:0] a,
                              input logic [31:0] n, input logic [15:0] fl, input logic [15:0] nx);
    po(t + 16 * i, a[31:0]);
    po(t + 16 * i + 4, a[63:32]);
    po(t + 16 * i + 8, n);
    po(t + 16 * i + 12, {nx, fl});
  endfunction
  function automatic void desc(input int i, input logic [63:0] a, input logic [31:0] n,
                               input logic [15:0] fl, input logic [15:0] nx);
    ent(DB, i, a, n, fl, nx);
  endfunction
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rq <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    rq <= '0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rq <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    rq <= '0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic wait_ev(input bit for_err);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if ((for_err ? err : used_ev) === 1'b1) break;
    end
    if (n == 3000) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic put_word(input logic [31:0] d, input logic last);
    int n;
    @(posedge clk);
    in_s <= '{valid: 1'b1, data: d, last: last};
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (in_rdy === 1'b1) break;
    end
    in_s <= '{valid: 1'b0, data: ~d, last: 1'b0};
    if (n == 3000) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic s_reset_values;
    logic [31:0] d;
    reg_rd(`SVQ_REG_QSIZE, d);
    check("qsize reset", d, 64'h100);
    @(posedge clk);
    check("rdata after read", rdata, 64'h0);
    reg_rd(`SVQ_REG_LIMIT, d);
    check("limit reset", d, 64'h40);
    reg_rd(8'h3c, d);
    check("unmapped read", d, 64'h0);
    // legacy layout from page frame 5 with 256 entries
    reg_wr(`SVQ_REG_PFN, 32'h5);
    reg_rd(`SVQ_REG_DESC_LO, d);
    check("legacy table", d, 64'h5000);
    reg_rd(`SVQ_REG_AVAIL_LO, d);
    check("legacy avail", d, 64'h6000);
    reg_rd(`SVQ_REG_USED_LO, d);
    check("legacy used", d, 64'h7000);
  endtask
  task automatic s_bad_qsize;
    logic [31:0] d;
    reg_wr(`SVQ_REG_QSIZE, 32'h3);
    reg_rd(`SVQ_REG_STATUS, d);
    check("bad qsize status", d[3:0], 64'h9);
    check("bad qsize error", err, 64'h1);
    reg_rd(`SVQ_REG_QSIZE, d);
    check("qsize kept", d, 64'h100);
    reg_wr(`SVQ_REG_STATUS, 32'h1);
    reg_rd(`SVQ_REG_STATUS, d);
    check("error cleared", d[0], 64'h0);
  endtask
  task automatic s_readable_chain;
    reg_wr(`SVQ_REG_QSIZE, 32'h4);
    reg_wr(`SVQ_REG_DESC_LO, DB[31:0]);
    reg_wr(`SVQ_REG_AVAIL_LO, AB[31:0]);
    reg_wr(`SVQ_REG_USED_LO, UB[31:0]);
    reg_wr(`SVQ_REG_CTRL, 32'h1);
    desc(0, RB, 32'h4, `SVQ_F_NEXT, 16'h1);
    desc(1, RB + 16, 32'h8, 16'h0, 16'h0);
    po(RB, 32'h1111_1111);
    po(RB + 16, 32'h2222_2222);
    po(RB + 20, 32'h3333_3333);
    po(UB, 32'h0);
    po(AB + 4, 32'h0);
    po(AB, 32'h0001_0000);
    reg_wr(`SVQ_REG_NOTIFY, 32'h0);
    wait_ev(1'b0);
    check("used idx at notify", pk(UB) >> 16, 64'h1);
    check("used id", pk(UB + 4), 64'h0);
    check("used len read only", pk(UB + 8), 64'h0);
    check("words out", outq.size(), 64'h3);
    check("word 0", outq[0], {1'b1, 32'h1111_1111});
    check("word 1", outq[1], {1'b0, 32'h2222_2222});
    check("word 2", outq[2], {1'b1, 32'h3333_3333});
    @(posedge clk);
    check("notify pulse", used_ev, 64'h0);
  endtask
  task automatic s_mixed_chain;
    slow <= 1'b1;
    outq.delete();
    desc(2, RB + 32, 32'h4, `SVQ_F_NEXT, 16'h3);
    desc(3, WB, 32'h8, `SVQ_F_WRITE, 16'h0);
    po(RB + 32, 32'h4444_4444);
    po(WB, 32'ha5a5_a5a5);
    po(WB + 4, 32'h5a5a_5a5a);
    po(AB + 4, 32'h0002_0000);
    po(AB, 32'h0002_0000);
    @(posedge clk);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    put_word(32'hcafe_0001, 1'b1);
    wait_ev(1'b0);
    check("used idx", pk(UB) >> 16, 64'h2);
    check("used id", pk(UB + 12), 64'h2);
    check("used len", pk(UB + 16), 64'h4);
    check("written word", pk(WB), 64'hcafe_0001);
    check("untouched tail", pk(WB + 4), 64'h5a5a_5a5a);
    check("readable intact", pk(RB + 32), 64'h4444_4444);
    check("read word", outq[0], {1'b1, 32'h4444_4444});
  endtask
  task automatic s_indirect;
    logic [31:0] d;
    outq.delete();
    desc(0, RB + 64'h200, 32'h20, `SVQ_F_INDIRECT, 16'h0);
    ent(RB + 64'h200, 0, RB + 48, 32'h4, `SVQ_F_NEXT, 16'h1);
    ent(RB + 64'h200, 1, WB + 16, 32'h3, `SVQ_F_WRITE, 16'h0);
    po(RB + 48, 32'h6666_6666);
    po(WB + 16, 32'heeee_eeee);
    po(AB + 8, 32'h0);
    po(AB, 32'h0003_0000);
    reg_wr(`SVQ_REG_NOTIFY, 32'h0);
    put_word(32'h1234_5678, 1'b1);
    wait_ev(1'b0);
    check("ind used idx", pk(UB) >> 16, 64'h3);
    check("ind used id", pk(UB + 20), 64'h0);
    check("ind used len", pk(UB + 24), 64'h3);
    check("ind partial word", pk(WB + 16), 64'hee34_5678);
    check("ind words out", outq.size(), 64'h1);
    check("ind read word", outq[0], {1'b1, 32'h6666_6666});
    reg_rd(`SVQ_REG_INDEX, d);
    check("index reg", d, 64'h0003_0003);
  endtask
  task automatic s_loop_chain;
    logic [31:0] d;
    reg_wr(`SVQ_REG_LIMIT, 32'h2);
    // self loop: the engine must give up instead of spinning
    desc(0, RB, 32'h4, `SVQ_F_NEXT, 16'h0);
    po(AB + 8, 32'h0);
    po(AB, 32'h0004_0000);
    reg_wr(`SVQ_REG_NOTIFY, 32'h0);
    wait_ev(1'b1);
    reg_rd(`SVQ_REG_STATUS, d);
    check("loop cause", d[3:0], 64'h3);
    check("no used entry", pk(UB) >> 16, 64'h3);
    reg_wr(`SVQ_REG_STATUS, 32'h1);
    @(posedge clk);
    check("error cleared", err, 64'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    s_reset_values();
    s_bad_qsize();
    s_readable_chain();
    s_mixed_chain();
    s_indirect();
    s_loop_chain();
    wrap_up();
  end
endmodule
`default_nettype wire
